// ---- core/pixel_unpack_color_lut.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lut_consts.svh"
// Notes on behaviour
// R1: 15 bpp: bit 15 unused, red 14:10, green 9:5, blue 4:0.
// R2: 16 bpp: red 15:11, green 10:5, blue 4:0.
// R3: 15/16 bpp bypass tables, components go straight to modulator.
// R4: Dither enable bit gives full colour range on every display.
// R5: Dither off: passive panels keep top four bits per component.
// R6: Mono 15 bpp sends five green bits; dither off caps 16 levels.
// R7: Mono 16 bpp sends six green bits; dither off caps 16 levels.
// R8: Two independent 256-entry RGB tables, panel and CRT.
// R9: 4 bpp uses first 16 entries; 8 bpp all 256.
// R10: Colour selects full RGB; mono panel uses green only.
// R11: CRT path always takes all three table components.
// R12: Two-bit mode field picks tables reached by CPU accesses.
// R13: Mode zero reads panel table, writes both tables.
// R14: 8-bit index register; writing it resets pointer to red.
// R15: Every third data access increments the index.
// R16: Data in upper nibble; pointer steps red, green, blue.
// R17: After blue the pointer returns to red with the increment.
// R18: 4 bpp: two pixels a byte, upper nibble first.
// R19: 8 bpp: each byte is one table index.
// R20: Unused mode and data bits read zero, writes ignored.
// R21: Pointer points to red after reset.
module pixel_unpack_color_lut
	import lut_pkg::*;
#(
	parameter int ENTRIES = 256,
	parameter int AW      = 8,
	parameter int CW      = 4
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        pix_valid,
	input  wire logic [15:0] pix_word,
	output logic             out_valid,
	output logic      [5:0]  panel_r,
	output logic      [5:0]  panel_g,
	output logic      [5:0]  panel_b,
	output logic      [5:0]  crt_r,
	output logic      [5:0]  crt_g,
	output logic      [5:0]  crt_b
);
	// Register state
	logic [1:0]    mode_ff;
	logic [AW-1:0] index_ff;
	bank_t         bank_ff;
	bank_t         nxt_bank;
	logic [4:0]    cfg_ff;
	logic          half_ff;
	logic [7:0]    rdata_ff;
	logic [5:0]    p_r_ff;
	logic [5:0]    p_g_ff;
	logic [5:0]    p_b_ff;
	logic [5:0]    c_r_ff;
	logic [5:0]    c_g_ff;
	logic [5:0]    c_b_ff;
	logic          valid_ff;

	// Bus decode and datapath wiring
	logic          wr_mode;
	logic          wr_index;
	logic          data_acc;
	logic          we_panel;
	logic          we_crt;
	logic [CW-1:0] rd_panel;
	logic [CW-1:0] rd_crt;
	logic [AW-1:0] pix_idx;
	logic [CW-1:0] lp_r, lp_g, lp_b;
	logic [CW-1:0] lc_r, lc_g, lc_b;
	logic [4:0]    u_r;
	logic [5:0]    u_g;
	logic [4:0]    u_b;
	depth_t        depth;
	logic          dither_on;
	logic          color_panel;
	logic          active_panel;
	logic          direct;
	logic          full_range;
	logic [5:0]    f_r;
	logic [5:0]    f_g;
	logic [5:0]    f_b;
	logic [7:0]    nxt_rdata;
	logic [AW-1:0] nxt_index;
	logic [`LOW_INDEX_W-1:0] nibble;

	// Register address decode, shared by every access
	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction : hit

	// Passive panel without dither keeps the top four bits
	function automatic logic [5:0] top4(input logic [5:0] v);
		top4 = {v[5:2], 2'h0};
	endfunction : top4

	// Pixel configuration word:
	// [1:0] depth: 0 4 bpp, 1 8 bpp, 3 15 bpp, 2 16 bpp
	// [2] dither enable, [3] colour panel
	// [4] active matrix panel
	assign depth        = depth_t'(cfg_ff[`CFG_DEPTH_LSB +: $bits(depth_t)]);
	assign dither_on    = cfg_ff[`CFG_DITHER_BIT];
	assign color_panel  = cfg_ff[`CFG_COLOR_BIT];
	assign active_panel = cfg_ff[`CFG_ACTIVE_BIT];
	assign direct       = (depth == DEPTH_15) || (depth == DEPTH_16);
	assign full_range   = dither_on || active_panel;
	// Unpacked components aligned to the output MSB
	assign f_r          = {u_r, 1'b0};
	assign f_g          = u_g;
	assign f_b          = {u_b, 1'b0};

	assign wr_mode  = reg_wr && hit(reg_addr, `REG_LUT_SELECT_MODE);
	assign wr_index = reg_wr && hit(reg_addr, `REG_LUT_ENTRY_INDEX);
	assign data_acc = (reg_wr || reg_rd)
		&& hit(reg_addr, `REG_LUT_COMPONENT_VALUE);

	// Mode three writes both, reads panel
	// R12: mode picks target tables
	// R13: mode zero writes both
	assign we_panel = reg_wr && data_acc && (mode_ff != `MODE_CRT_ONLY);
	assign we_crt   = reg_wr && data_acc && (mode_ff != `MODE_PANEL_ONLY);

	// R8: two independent tables
	color_table #(.ENTRIES(ENTRIES), .AW(AW), .CW(CW)) u_panel (
		.clk    (clk),
		.we     (we_panel),
		.waddr  (index_ff),
		.wbank  (bank_ff),
		.wdata  (reg_wdata[`DATA_MSB:`DATA_LSB]),
		.rbank  (bank_ff),
		.rdata  (rd_panel),
		.pix_idx(pix_idx),
		.pix_r  (lp_r),
		.pix_g  (lp_g),
		.pix_b  (lp_b)
	);

	// CRT table, loaded beside the panel one in mode zero
	color_table #(.ENTRIES(ENTRIES), .AW(AW), .CW(CW)) u_crt (
		.clk    (clk),
		.we     (we_crt),
		.waddr  (index_ff),
		.wbank  (bank_ff),
		.wdata  (reg_wdata[`DATA_MSB:`DATA_LSB]),
		.rbank  (bank_ff),
		.rdata  (rd_crt),
		.pix_idx(pix_idx),
		.pix_r  (lc_r),
		.pix_g  (lc_g),
		.pix_b  (lc_b)
	);

	// Direct colour splitter for 15 and 16 bpp
	pixel_unpack u_unpack (
		.pixel(pix_word),
		.is_16(depth == DEPTH_16),
		.red  (u_r),
		.green(u_g),
		.blue (u_b)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_ff <= `MODE_BOTH;
		end else if (wr_mode) begin
			// R20: upper bits dropped
			mode_ff <= reg_wdata[`MODE_FIELD_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_ff <= 5'h00;
		end else if (reg_wr && hit(reg_addr, `REG_PIXEL_CONFIG)) begin
			cfg_ff <= reg_wdata[4:0];
		end
	end

	// R16: red, green, blue order
	always_comb begin
		case (bank_ff)
			BANK_RED:   nxt_bank = BANK_GREEN;
			BANK_GREEN: nxt_bank = BANK_BLUE;
			// R17: blue wraps to red
			default:    nxt_bank = BANK_RED;
		endcase
	end

	// Component pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			// R21: red after reset
			bank_ff <= BANK_RED;
		end else if (wr_index) begin
			// R14: index write selects red
			bank_ff <= BANK_RED;
		end else if (data_acc) begin
			bank_ff <= nxt_bank;
		end
	end

	// Next table index: load, step or hold
	always_comb begin
		nxt_index = index_ff;
		if (wr_index) begin
			nxt_index = reg_wdata[AW-1:0];
		end else if (data_acc && bank_ff == BANK_BLUE) begin
			// R15: step after third access
			nxt_index = index_ff + AW'(1);
		end
	end

	// Index wraps from the last entry to zero
	always_ff @(posedge clk) begin
		if (rst) begin
			index_ff <= '0;
		end else begin
			index_ff <= nxt_index;
		end
	end

	// R13: mode zero reads panel table
	always_comb begin
		nxt_rdata = 8'h00;
		if (reg_rd && hit(reg_addr, `REG_LUT_SELECT_MODE)) begin
			nxt_rdata = {6'h00, mode_ff};
		end else if (reg_rd && hit(reg_addr, `REG_LUT_ENTRY_INDEX)) begin
			nxt_rdata = 8'(index_ff);
		end else if (reg_rd && data_acc) begin
			// Data reads also advance the pointer
			// R20: low nibble zero
			nxt_rdata = {(mode_ff == `MODE_CRT_ONLY) ? rd_crt
				: rd_panel, 4'h0};
		end else if (reg_rd && hit(reg_addr, `REG_PIXEL_CONFIG)) begin
			nxt_rdata = {3'h0, cfg_ff};
		end
	end

	// Read data stands one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign reg_rdata = rdata_ff;

	// R18: upper nibble first pixel
	always_ff @(posedge clk) begin
		if (rst || depth != DEPTH_4) begin
			half_ff <= 1'b0;
		end else if (pix_valid) begin
			half_ff <= ~half_ff;
		end
	end

	// Pixel within the byte, upper nibble while half is clear
	assign nibble = half_ff ? pix_word[3:0] : pix_word[7:4];

	// Table index by depth
	always_comb begin
		case (depth)
			// R9: 4 bpp first 16 entries
			DEPTH_4: pix_idx = {{(AW-`LOW_INDEX_W){1'b0}}, nibble};
			// R19: byte is the index
			default: pix_idx = pix_word[AW-1:0];
		endcase
	end

	// Output strobe follows the pixel qualifier by one cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= pix_valid;
		end
	end

	// CRT path never truncates
	always_ff @(posedge clk) begin
		if (rst) begin
			c_r_ff <= 6'h00;
			c_g_ff <= 6'h00;
			c_b_ff <= 6'h00;
		end else if (direct) begin
			// R3: tables bypassed
			c_r_ff <= f_r;
			c_g_ff <= f_g;
			c_b_ff <= f_b;
		end else begin
			// R11: CRT uses all three
			c_r_ff <= {lc_r, 2'h0};
			c_g_ff <= {lc_g, 2'h0};
			c_b_ff <= {lc_b, 2'h0};
		end
	end

	// Panel path: table, bypass, mono or truncated
	always_ff @(posedge clk) begin
		if (rst) begin
			p_r_ff <= 6'h00;
			p_g_ff <= 6'h00;
			p_b_ff <= 6'h00;
		end else if (!direct) begin
			// R10: mono uses green only
			p_r_ff <= color_panel ? {lp_r, 2'h0} : 6'h00;
			p_g_ff <= {lp_g, 2'h0};
			p_b_ff <= color_panel ? {lp_b, 2'h0} : 6'h00;
		end else if (!color_panel) begin
			// R6: mono 15 bpp five bits
			// R7: mono 16 bpp six bits
			p_r_ff <= 6'h00;
			p_g_ff <= full_range ? f_g : top4(f_g);
			p_b_ff <= 6'h00;
		end else if (full_range) begin
			// R4: full range dithered
			p_r_ff <= f_r;
			p_g_ff <= f_g;
			p_b_ff <= f_b;
		end else begin
			// R5: passive keeps top four bits
			p_r_ff <= top4(f_r);
			p_g_ff <= top4(f_g);
			p_b_ff <= top4(f_b);
		end
	end

	assign out_valid = valid_ff;
	assign panel_r   = p_r_ff;
	assign panel_g   = p_g_ff;
	assign panel_b   = p_b_ff;
	assign crt_r     = c_r_ff;
	assign crt_g     = c_g_ff;
	assign crt_b     = c_b_ff;
endmodule : pixel_unpack_color_lut
`default_nettype wire

// ---- core/lut_consts.svh ----
`ifndef LUT_CONSTS_SVH
`define LUT_CONSTS_SVH

`define REG_LUT_SELECT_MODE     12'h1e0
`define REG_LUT_ENTRY_INDEX     12'h1e2
`define REG_LUT_COMPONENT_VALUE 12'h1e4
`define REG_PIXEL_CONFIG        12'h1e6
`define MODE_FIELD_W            2
`define MODE_BOTH               2'h0
`define MODE_PANEL_ONLY         2'h1
`define MODE_CRT_ONLY           2'h2
`define DATA_MSB                7
`define DATA_LSB                4
`define CFG_DEPTH_LSB           0
`define CFG_DITHER_BIT          2
`define CFG_COLOR_BIT           3
`define CFG_ACTIVE_BIT          4
`define P15_R_MSB               14
`define P15_R_LSB               10
`define P15_G_MSB               9
`define P15_G_LSB               5
`define P16_R_MSB               15
`define P16_R_LSB               11
`define P16_G_MSB               10
`define P16_G_LSB               5
`define PB_MSB                  4
`define PB_LSB                  0
`define LOW_INDEX_W             4

`endif

// ---- core/lut_pkg.sv ----
package lut_pkg;
	typedef enum logic [1:0] {
		DEPTH_4  = 2'h0,
		DEPTH_8  = 2'h1,
		DEPTH_15 = 2'h3,
		DEPTH_16 = 2'h2
	} depth_t;
	typedef enum logic [1:0] {
		BANK_RED   = 2'h0,
		BANK_GREEN = 2'h1,
		BANK_BLUE  = 2'h3
	} bank_t;
endpackage : lut_pkg

// ---- core/color_table.sv ----
`timescale 1ns/1ps
`default_nettype none
// One 256 x RGB table, 4 bits a component, with a CPU port and a pixel port
module color_table #(
	parameter int ENTRIES = 256,
	parameter int AW      = 8,
	parameter int CW      = 4
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [1:0]    wbank,
	input  wire logic [CW-1:0] wdata,
	input  wire logic [1:0]    rbank,
	output logic      [CW-1:0] rdata,
	input  wire logic [AW-1:0] pix_idx,
	output logic      [CW-1:0] pix_r,
	output logic      [CW-1:0] pix_g,
	output logic      [CW-1:0] pix_b
);
	logic [CW-1:0] red_ff   [ENTRIES];
	logic [CW-1:0] green_ff [ENTRIES];
	logic [CW-1:0] blue_ff  [ENTRIES];

	always_ff @(posedge clk) begin
		if (we) begin
			case (wbank)
				2'h0:    red_ff[waddr]   <= wdata;
				2'h1:    green_ff[waddr] <= wdata;
				default: blue_ff[waddr]  <= wdata;
			endcase
		end
	end

	always_comb begin
		case (rbank)
			2'h0:    rdata = red_ff[waddr];
			2'h1:    rdata = green_ff[waddr];
			default: rdata = blue_ff[waddr];
		endcase
	end

	assign pix_r = red_ff[pix_idx];
	assign pix_g = green_ff[pix_idx];
	assign pix_b = blue_ff[pix_idx];
endmodule : color_table
`default_nettype wire

// ---- core/pixel_unpack.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lut_consts.svh"
// Splits a 15 or 16 bpp word into 5/6/5 components
module pixel_unpack
	import lut_pkg::*;
(
	input  wire logic [15:0] pixel,
	input  wire logic        is_16,
	output logic      [4:0]  red,
	output logic      [5:0]  green,
	output logic      [4:0]  blue
);
	always_comb begin
		blue = pixel[`PB_MSB:`PB_LSB];
		if (is_16) begin
			// R2: 5-6-5 split
			red   = pixel[`P16_R_MSB:`P16_R_LSB];
			green = pixel[`P16_G_MSB:`P16_G_LSB];
		end else begin
			// R1: top bit ignored
			red   = pixel[`P15_R_MSB:`P15_R_LSB];
			green = {pixel[`P15_G_MSB:`P15_G_LSB], 1'b0};
		end
	end
endmodule : pixel_unpack
`default_nettype wire

// ---- tb/lut_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module lut_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        pix_valid,
	input wire logic [15:0] pix_word,
	input wire logic [5:0]  panel_r,
	input wire logic [5:0]  panel_g,
	input wire logic [5:0]  panel_b,
	input wire logic [5:0]  crt_r,
	input wire logic [5:0]  crt_g,
	input wire logic [5:0]  crt_b
);
	logic [4:0]       cfg_ff;
	wire logic [17:0] pan = {panel_r, panel_g, panel_b};
	wire logic [17:0] crt = {crt_r, crt_g, crt_b};
	wire logic        pv16 = pix_valid && cfg_ff[1:0] == 2'h2;
	// Shadow of the pixel configuration
	always_ff @(posedge clk) begin
		if (rst)
			cfg_ff <= 5'h0;
		else if (reg_wr && reg_addr == 12'h1e6)
			cfg_ff <= reg_wdata[4:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	unmapped_rd_a: assert property (
		reg_rd && reg_addr[11:3] != 9'h03c |=> reg_rdata == 8'h0)
		else $error("unmapped read not zero");
	idx_rdback_a: assert property (
		reg_wr && reg_addr == 12'h1e2 ##1 !reg_wr && !reg_rd
		##1 reg_rd && reg_addr == 12'h1e2 |=> reg_rdata == $past(reg_wdata, 3))
		else $error("index readback wrong");
	p15_crt_a: assert property (
		pix_valid && cfg_ff[1:0] == 2'h3 |=> crt == {$past(pix_word[14:10]),
		1'h0, $past(pix_word[9:5]), 1'h0, $past(pix_word[4:0]), 1'h0})
		else $error("15 bpp unpack wrong");
	p16_crt_a: assert property (
		pv16 |=> crt == {$past(pix_word[15:11]), 1'h0,
		$past(pix_word[10:0]), 1'h0})
		else $error("16 bpp unpack wrong");
	passive_cut_a: assert property (
		pv16 && cfg_ff[4:2] == 3'h2 |=> pan == {$past(pix_word[15:12]), 2'h0,
		$past(pix_word[10:7]), 2'h0, $past(pix_word[4:1]), 2'h0})
		else $error("passive truncation wrong");
	full_panel_a: assert property (
		pv16 && cfg_ff[3] && cfg_ff[4:2] != 3'h2 |=> pan == crt)
		else $error("panel range not full");
	mono16_a: assert property (
		pv16 && cfg_ff[4:2] == 3'h1 |=> panel_g == $past(pix_word[10:5]))
		else $error("mono green wrong");
	mono_cap_a: assert property (
		pix_valid && cfg_ff[1] && cfg_ff[4:2] == 3'h0 |=> panel_g[1:0] == 2'h0)
		else $error("mono levels not capped");
	c4_c: cover property (pix_valid && cfg_ff[1:0] == 2'h0);
	c8_c: cover property (pix_valid && cfg_ff[1:0] == 2'h1);
	cdat_c: cover property (reg_rd && reg_addr == 12'h1e4);
endmodule : lut_chk
`default_nettype wire

// ---- tb/host_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
	input  wire logic        clk,
	output logic      [11:0] reg_addr,
	output logic      [7:0]  reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [7:0]  reg_rdata
);
	initial begin
		reg_addr = 12'h0;
		reg_wdata = 8'h0;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
	end
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		reg_wdata <= ~v;
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd
	task automatic entry(input logic [7:0] i, input logic [11:0] rgb);
		wr(12'h1e2, i);
		wr(12'h1e4, {rgb[11:8], 4'h5});
		wr(12'h1e4, {rgb[7:4], 4'ha});
		wr(12'h1e4, {rgb[3:0], 4'h0});
	endtask : entry
endmodule : host_cpu_model
`default_nettype wire

// ---- tb/pixel_unpack_color_lut_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module pixel_unpack_color_lut_tb;
	typedef struct packed {
		logic [4:0]  cfg;
		logic [15:0] word;
		logic [17:0] pan;
		logic [17:0] crt;
	} row_t;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        pix_valid = 1'h0;
	logic [15:0] pix_word = 16'h0;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic        reg_wr, reg_rd, out_valid;
	logic [5:0]  panel_r, panel_g, panel_b, crt_r, crt_g, crt_b;
	int          err_total = 0;
	int          check_count = 0;
	row_t        rows [12];
	always #12.5 clk = ~clk;
	host_cpu_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	pixel_unpack_color_lut dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_word(pix_word),
		.out_valid(out_valid), .panel_r(panel_r), .panel_g(panel_g),
		.panel_b(panel_b), .crt_r(crt_r), .crt_g(crt_g), .crt_b(crt_b));
	task automatic end_sim;
		if (err_total == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [11:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk({10'h0, d}, {10'h0, e});
	endtask : rchk
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim();
	end
	initial begin
		rows = '{'{5'h01, 16'hc305, 18'h00300, 18'h28330},
			'{5'h09, 16'h0006, 18'h0420c, 18'h10518},
			'{5'h08, 16'h9a56, 18'h28330, 18'h28330},
			'{5'h08, 16'h0056, 18'h0420c, 18'h10518},
			'{5'h1a, 16'h8c71, 18'h228e2, 18'h228e2},
			'{5'h0a, 16'h8c71, 18'h20820, 18'h228e2},
			'{5'h0e, 16'h8c71, 18'h228e2, 18'h228e2},
			'{5'h0f, 16'h8421, 18'h02082, 18'h02082},
			'{5'h07, 16'h03e0, 18'h00f80, 18'h00f80},
			'{5'h06, 16'h07e0, 18'h00fc0, 18'h00fc0},
			'{5'h02, 16'h07e0, 18'h00f00, 18'h00fc0},
			'{5'h03, 16'h83e0, 18'h00f00, 18'h00f80}};
		repeat (16) @(posedge clk);
		rst <= 1'h0;
		rchk(12'h1e0, 8'h00);
		rchk(12'h1e2, 8'h00);
		host.entry(8'h05, 12'ha3c);
		host.wr(12'h1e0, 8'h01);
		host.entry(8'h06, 12'h123);
		host.wr(12'h1e0, 8'h02);
		host.entry(8'h06, 12'h456);
		host.wr(12'h1e0, 8'h00);
		foreach (rows[i]) begin
			host.wr(12'h1e6, {3'h0, rows[i].cfg});
			@(posedge clk);
			pix_valid <= 1'h1;
			pix_word <= rows[i].word;
			@(posedge clk);
			pix_valid <= 1'h0;
			@(negedge clk);
			chk({17'h0, out_valid}, 18'h1);
			chk({panel_r, panel_g, panel_b}, rows[i].pan);
			chk({crt_r, crt_g, crt_b}, rows[i].crt);
		end
		host.wr(12'h1e2, 8'h5a);
		rchk(12'h1e2, 8'h5a);
		host.wr(12'h1e2, 8'h05);
		rchk(12'h1e4, 8'ha0);
		host.wr(12'h1e2, 8'h05);
		rchk(12'h1e4, 8'ha0);
		rchk(12'h1e4, 8'h30);
		rchk(12'h1e4, 8'hc0);
		rchk(12'h1e2, 8'h06);
		rchk(12'h1e4, 8'h10);
		host.wr(12'h1e0, 8'h02);
		host.wr(12'h1e2, 8'h06);
		rchk(12'h1e4, 8'h40);
		host.wr(12'h1e0, 8'hff);
		rchk(12'h1e0, 8'h03);
		host.wr(12'h1e0, 8'h00);
		host.entry(8'hff, 12'h789);
		rchk(12'h1e2, 8'h00);
		rchk(12'h100, 8'h00);
		host.wr(12'h1e4, 8'h70);
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		rchk(12'h1e4, 8'h70);
		end_sim();
	end
endmodule : pixel_unpack_color_lut_tb
bind pixel_unpack_color_lut lut_chk chk_i (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
	.pix_word(pix_word), .panel_r(panel_r), .panel_g(panel_g),
	.panel_b(panel_b), .crt_r(crt_r), .crt_g(crt_g), .crt_b(crt_b));
`default_nettype wire
